// *** shared/txcfg_defines.svh ***
// Register offsets, field positions and reset values of the config bank
`ifndef TXCFG_DEFINES_SVH
`define TXCFG_DEFINES_SVH
`define TXCFG_ADDR_SYNC_HI    6'h04
`define TXCFG_ADDR_SYNC_LO    6'h05
`define TXCFG_ADDR_PKT_LEN    6'h06
`define TXCFG_ADDR_PKT_CTRL   6'h08
`define TXCFG_ADDR_CHANNEL_INDEX       6'h0A
`define TXCFG_ADDR_BASE_FREQUENCY_WORD_HI    6'h0D
`define TXCFG_ADDR_BASE_FREQUENCY_WORD_MID   6'h0E
`define TXCFG_ADDR_BASE_FREQUENCY_WORD_LO    6'h0F
`define TXCFG_ADDR_RATE_EXP   6'h10
`define TXCFG_ADDR_RATE_MANT  6'h11
`define TXCFG_RST_SYNC_HI     8'hD3
`define TXCFG_RST_SYNC_LO     8'h91
`define TXCFG_RST_PKT_LEN     8'hFF
`define TXCFG_RST_PKT_CTRL    7'h45
`define TXCFG_RST_CHANNEL_INDEX        8'h00
`define TXCFG_RST_BASE_FREQUENCY_WORD_HI     6'h1E
`define TXCFG_RST_BASE_FREQUENCY_WORD_MID    8'hC4
`define TXCFG_RST_BASE_FREQUENCY_WORD_LO     8'hEC
`define TXCFG_RST_RATE_EXP    4'hC
`define TXCFG_RST_RATE_MANT   8'h22
`define TXCFG_BASE_FREQUENCY_WORD_TOP        2'h1
`define TXCFG_BIT_WHITE       6
`define TXCFG_BIT_FMT_HI      5
`define TXCFG_BIT_FMT_LO      4
`define TXCFG_BIT_LEGACY      3
`define TXCFG_BIT_CRC         2
`define TXCFG_BIT_LEN_HI      1
`define TXCFG_BIT_LEN_LO      0
`endif

// *** shared/txcfg_pkg.sv ***
// Types for the transmit configuration bank
package txcfg_pkg;
  typedef enum logic [1:0] {
    TXCFG_SRC_BUFFER, TXCFG_SRC_SYNC_SERIAL,
    TXCFG_SRC_RANDOM, TXCFG_SRC_ASYNC_PIN
  } txcfg_src_t;
  typedef enum logic [1:0] {
    TXCFG_LEN_FIXED, TXCFG_LEN_VARIABLE,
    TXCFG_LEN_INFINITE, TXCFG_LEN_RESERVED
  } txcfg_len_t;
endpackage

// *** rtl/txcfg_mode_decode.sv ***
// Decodes packet control fields into one-hot mode strobes
`timescale 1ns/10ps
`include "txcfg_defines.svh"
module txcfg_mode_decode
  import txcfg_pkg::*;
(
  // Packet control byte
  input  wire logic [6:0] pktCtrl,
  // Data source selects
  output logic            srcBuffer,
  output logic            srcSyncSerial,
  output logic            srcRandom,
  output logic            srcAsyncPin,
  // Length mode selects
  output logic            lenFixed,
  output logic            lenVariable,
  output logic            lenInfinite,
  output logic            lenReserved
);
  txcfg_src_t src;
  txcfg_len_t len;

  // Field extraction
  always_comb begin
    src = txcfg_src_t'(pktCtrl[`TXCFG_BIT_FMT_HI:`TXCFG_BIT_FMT_LO]);
    len = txcfg_len_t'(pktCtrl[`TXCFG_BIT_LEN_HI:`TXCFG_BIT_LEN_LO]);
  end

  // Source decode
  assign srcBuffer     = (src == TXCFG_SRC_BUFFER);      // [RULE6]
  assign srcSyncSerial = (src == TXCFG_SRC_SYNC_SERIAL); // [RULE7]
  assign srcRandom     = (src == TXCFG_SRC_RANDOM);      // [RULE8]
  assign srcAsyncPin   = (src == TXCFG_SRC_ASYNC_PIN);   // [RULE9]
  // Length decode; reserved code is flagged, not acted on
  assign lenFixed      = (len == TXCFG_LEN_FIXED);       // [RULE12]
  assign lenVariable   = (len == TXCFG_LEN_VARIABLE);    // [RULE13]
  assign lenInfinite   = (len == TXCFG_LEN_INFINITE);    // [RULE14]
  assign lenReserved   = (len == TXCFG_LEN_RESERVED);    // [RULE14]
endmodule

// *** rtl/txcfg_bank.sv ***
// Transmit packet and modem configuration register bank
//
// Contract
// RULE1: Sync high byte read/write, resets to D3
// RULE2: Sync low byte read/write, resets to 91
// RULE3: Length byte FF, used in fixed mode
// RULE4: Control bit 6 enables whitening, reset one
// RULE5: Host keeps whitening off with legacy CRC
// RULE6: Format 00 sends from transmit buffer
// RULE7: Format 01 selects synchronous serial mode
// RULE8: Format 10 sends nine-bit pseudo-random data
// RULE9: Format 11 takes data from pin 0
// RULE10: Control bit 3 selects legacy CRC
// RULE11: Control bit 2 enables CRC, reset one
// RULE12: Length 00 means fixed length packets
// RULE13: Length 01, reset, means variable length
// RULE14: Length 10 infinite, 11 reserved
// RULE15: Channel byte, reset zero, scales spacing
// RULE16: Frequency top bits read 01 always
// RULE17: Frequency word resets 1E C4 EC
// RULE18: Rate exponent low nibble, reset 12
// RULE19: Rate mantissa 22 with hidden one
// RULE20: Exponent byte upper nibble reads zero
`timescale 1ns/10ps
`include "txcfg_defines.svh"
module txcfg_bank
  import txcfg_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Register port from the serial interface
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regWdata,
  output logic      [7:0]        regRdata,
  output logic                   regRvalid,
  output logic                   regHit,
  // Packet handler settings
  output logic      [15:0]       syncWord,
  output logic      [7:0]        fixedPacketLength,
  output logic                   whiteningEnable,
  output logic                   legacyCrcCompat,
  output logic                   crcEnable,
  output logic                   srcBuffer,
  output logic                   srcSyncSerial,
  output logic                   srcRandom,
  output logic                   srcAsyncPin,
  output logic                   lenFixed,
  output logic                   lenVariable,
  output logic                   lenInfinite,
  output logic                   lenReserved,
  output logic                   whiteningConflict,
  // Synthesizer and modulator settings
  output logic      [7:0]        channelIndex,
  output logic      [23:0]       baseFrequencyWord,
  output logic      [3:0]        symbolRateExponentField,
  output logic      [8:0]        symbolRateMantissaFull
);
  // Stored register state
  logic [7:0] syncHi_q, syncHi_d;
  logic [7:0] syncLo_q, syncLo_d;
  logic [7:0] fixed_packet_length_q, fixed_packet_length_d;
  logic [6:0] pktCtrl_q, pktCtrl_d;
  logic [7:0] channel_index_q, channel_index_d;
  logic [5:0] freqHi_q, freqHi_d;
  logic [7:0] freqMid_q, freqMid_d;
  logic [7:0] freqLo_q, freqLo_d;
  logic [3:0] rateExp_q, rateExp_d;
  logic [7:0] rateMant_q, rateMant_d;
  // Read port state
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       hit_q, hit_d;
  // Registered mode outputs
  logic [7:0] modes_q, modes_d;
  logic       conflict_q, conflict_d;
  // Decoder outputs
  logic dSrcBuf, dSrcSync, dSrcRnd, dSrcPin;
  logic dLenFix, dLenVar, dLenInf, dLenRes;

  // Address decode used only for the read hit flag; the write path has its own case
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    case (a)
      `TXCFG_ADDR_SYNC_HI, `TXCFG_ADDR_SYNC_LO, `TXCFG_ADDR_PKT_LEN,
      `TXCFG_ADDR_PKT_CTRL, `TXCFG_ADDR_CHANNEL_INDEX, `TXCFG_ADDR_BASE_FREQUENCY_WORD_HI,
      `TXCFG_ADDR_BASE_FREQUENCY_WORD_MID, `TXCFG_ADDR_BASE_FREQUENCY_WORD_LO, `TXCFG_ADDR_RATE_EXP,
      `TXCFG_ADDR_RATE_MANT: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Register write path; writes to read-only bits are dropped
  always_comb begin
    syncHi_d   = syncHi_q;
    syncLo_d   = syncLo_q;
    fixed_packet_length_d   = fixed_packet_length_q;
    pktCtrl_d  = pktCtrl_q;
    channel_index_d     = channel_index_q;
    freqHi_d   = freqHi_q;
    freqMid_d  = freqMid_q;
    freqLo_d   = freqLo_q;
    rateExp_d  = rateExp_q;
    rateMant_d = rateMant_q;
    if (regWrite) begin
      case (regAddr)
        `TXCFG_ADDR_SYNC_HI:   syncHi_d   = regWdata;      // [RULE1]
        `TXCFG_ADDR_SYNC_LO:   syncLo_d   = regWdata;      // [RULE2]
        `TXCFG_ADDR_PKT_LEN:   fixed_packet_length_d   = regWdata;      // [RULE3]
        // Bit 7 of control is read-only zero
        `TXCFG_ADDR_PKT_CTRL:  pktCtrl_d  = regWdata[6:0]; // [RULE4]
        `TXCFG_ADDR_CHANNEL_INDEX:      channel_index_d     = regWdata;      // [RULE15]
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_HI:   freqHi_d   = regWdata[5:0]; // [RULE16]
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_MID:  freqMid_d  = regWdata;      // [RULE17]
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_LO:   freqLo_d   = regWdata;      // [RULE17]
        `TXCFG_ADDR_RATE_EXP:  rateExp_d  = regWdata[3:0]; // [RULE18]
        `TXCFG_ADDR_RATE_MANT: rateMant_d = regWdata;      // [RULE19]
        default: ;
      endcase
    end
  end

  // Configuration registers with their power-up values
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncHi_q   <= `TXCFG_RST_SYNC_HI;   // [RULE1]
      syncLo_q   <= `TXCFG_RST_SYNC_LO;   // [RULE2]
      fixed_packet_length_q   <= `TXCFG_RST_PKT_LEN;   // [RULE3]
      pktCtrl_q  <= `TXCFG_RST_PKT_CTRL;  // [RULE4] [RULE11] [RULE13]
      channel_index_q     <= `TXCFG_RST_CHANNEL_INDEX;      // [RULE15]
      freqHi_q   <= `TXCFG_RST_BASE_FREQUENCY_WORD_HI;   // [RULE17]
      freqMid_q  <= `TXCFG_RST_BASE_FREQUENCY_WORD_MID;  // [RULE17]
      freqLo_q   <= `TXCFG_RST_BASE_FREQUENCY_WORD_LO;   // [RULE17]
      rateExp_q  <= `TXCFG_RST_RATE_EXP;  // [RULE18]
      rateMant_q <= `TXCFG_RST_RATE_MANT; // [RULE19]
    end else begin
      syncHi_q   <= syncHi_d;
      syncLo_q   <= syncLo_d;
      fixed_packet_length_q   <= fixed_packet_length_d;
      pktCtrl_q  <= pktCtrl_d;
      channel_index_q     <= channel_index_d;
      freqHi_q   <= freqHi_d;
      freqMid_q  <= freqMid_d;
      freqLo_q   <= freqLo_d;
      rateExp_q  <= rateExp_d;
      rateMant_q <= rateMant_d;
    end
  end

  // Read path; reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = regRead;
    hit_d    = hit_q;
    if (regRead) begin
      hit_d = isMapped(regAddr);
      case (regAddr)
        `TXCFG_ADDR_SYNC_HI:   rdata_d = syncHi_q;
        `TXCFG_ADDR_SYNC_LO:   rdata_d = syncLo_q;
        `TXCFG_ADDR_PKT_LEN:   rdata_d = fixed_packet_length_q;
        `TXCFG_ADDR_PKT_CTRL:  rdata_d = {1'b0, pktCtrl_q};
        `TXCFG_ADDR_CHANNEL_INDEX:      rdata_d = channel_index_q;
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_HI:   rdata_d = {`TXCFG_BASE_FREQUENCY_WORD_TOP, freqHi_q}; // [RULE16]
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_MID:  rdata_d = freqMid_q;
        `TXCFG_ADDR_BASE_FREQUENCY_WORD_LO:   rdata_d = freqLo_q;
        `TXCFG_ADDR_RATE_EXP:  rdata_d = {4'h0, rateExp_q}; // [RULE20]
        `TXCFG_ADDR_RATE_MANT: rdata_d = rateMant_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  // Mode strobes registered so every output comes from a flop
  always_comb begin
    modes_d = {dSrcBuf, dSrcSync, dSrcRnd, dSrcPin,
               dLenFix, dLenVar, dLenInf, dLenRes};
    // Host misuse is only reported; the bank never overrides software
    conflict_d = pktCtrl_q[`TXCFG_BIT_WHITE]
               & pktCtrl_q[`TXCFG_BIT_LEGACY]; // [RULE5]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q    <= 8'h00;
      rvalid_q   <= 1'b0;
      hit_q      <= 1'b0;
      modes_q    <= 8'h00;
      conflict_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      hit_q      <= hit_d;
      modes_q    <= modes_d;
      conflict_q <= conflict_d;
    end
  end

  // Field decoder for source and length modes
  txcfg_mode_decode uDecode (
    .pktCtrl       (pktCtrl_q),
    .srcBuffer     (dSrcBuf),
    .srcSyncSerial (dSrcSync),
    .srcRandom     (dSrcRnd),
    .srcAsyncPin   (dSrcPin),
    .lenFixed      (dLenFix),
    .lenVariable   (dLenVar),
    .lenInfinite   (dLenInf),
    .lenReserved   (dLenRes)
  );

  // Outputs straight from flops
  assign regRdata          = rdata_q;
  assign regRvalid         = rvalid_q;
  assign regHit            = hit_q;
  assign syncWord          = {syncHi_q, syncLo_q};          // [RULE1] [RULE2]
  assign fixedPacketLength = fixed_packet_length_q;                      // [RULE3]
  assign whiteningEnable   = pktCtrl_q[`TXCFG_BIT_WHITE];   // [RULE4]
  assign legacyCrcCompat   = pktCtrl_q[`TXCFG_BIT_LEGACY];  // [RULE10]
  assign crcEnable         = pktCtrl_q[`TXCFG_BIT_CRC];     // [RULE11]
  assign {srcBuffer, srcSyncSerial, srcRandom, srcAsyncPin,
          lenFixed, lenVariable, lenInfinite, lenReserved} = modes_q;
  assign whiteningConflict = conflict_q;
  assign channelIndex      = channel_index_q;                        // [RULE15]
  assign baseFrequencyWord = {`TXCFG_BASE_FREQUENCY_WORD_TOP, freqHi_q,
                              freqMid_q, freqLo_q};         // [RULE16] [RULE17]
  assign symbolRateExponentField = rateExp_q;               // [RULE18]
  // Hidden leading one prepended to the stored mantissa
  assign symbolRateMantissaFull  = {1'b1, rateMant_q};      // [RULE19]

  // Power-up values at the first edge after reset release, mode strobes one edge later
  sync_reset_a: assert property (@(posedge clk_sys) // [RULE1] [RULE2]
    $fell(sys_rst) |-> syncWord == {`TXCFG_RST_SYNC_HI, `TXCFG_RST_SYNC_LO})
    else $error("sync word reset value wrong");
  len_reset_a: assert property (@(posedge clk_sys) // [RULE3] [RULE11]
    $fell(sys_rst) |-> fixedPacketLength == `TXCFG_RST_PKT_LEN &&
    crcEnable && whiteningEnable && !legacyCrcCompat)
    else $error("control reset wrong");
  mode_reset_a: assert property (@(posedge clk_sys) // [RULE6] [RULE13]
    $fell(sys_rst) |=> srcBuffer && lenVariable)
    else $error("mode strobes after reset wrong");
  base_frequency_word_reset_a: assert property (@(posedge clk_sys) // [RULE17] [RULE18]
    $fell(sys_rst) |-> baseFrequencyWord == {`TXCFG_BASE_FREQUENCY_WORD_TOP,
    `TXCFG_RST_BASE_FREQUENCY_WORD_HI, `TXCFG_RST_BASE_FREQUENCY_WORD_MID, `TXCFG_RST_BASE_FREQUENCY_WORD_LO} &&
    symbolRateExponentField == `TXCFG_RST_RATE_EXP)
    else $error("frequency or exponent reset wrong");
  // Writes land on the outputs one edge after the strobe
  sync_high_wr_a: assert property (@(posedge clk_sys) // [RULE1]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_SYNC_HI |=>
    syncWord[15:8] == $past(regWdata))
    else $error("sync high write lost");
  sync_low_wr_a: assert property (@(posedge clk_sys) // [RULE2]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_SYNC_LO |=>
    syncWord[7:0] == $past(regWdata))
    else $error("sync low write lost");
  len_wr_a: assert property (@(posedge clk_sys) // [RULE3]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_LEN |=>
    fixedPacketLength == $past(regWdata))
    else $error("packet length write lost");
  white_wr_a: assert property (@(posedge clk_sys) // [RULE4]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL |=>
    whiteningEnable == $past(regWdata[`TXCFG_BIT_WHITE]))
    else $error("whitening bit write lost");
  legacy_wr_a: assert property (@(posedge clk_sys) // [RULE10]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL |=>
    legacyCrcCompat == $past(regWdata[`TXCFG_BIT_LEGACY]))
    else $error("legacy crc bit write lost");
  crc_wr_a: assert property (@(posedge clk_sys) // [RULE11]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL |=>
    crcEnable == $past(regWdata[`TXCFG_BIT_CRC]))
    else $error("crc enable write lost");
  channel_index_wr_a: assert property (@(posedge clk_sys) // [RULE15]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_CHANNEL_INDEX |=>
    channelIndex == $past(regWdata))
    else $error("channel write lost");
  base_frequency_word_wr_a: assert property (@(posedge clk_sys) // [RULE17]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_BASE_FREQUENCY_WORD_MID |=>
    baseFrequencyWord[15:8] == $past(regWdata))
    else $error("frequency middle write lost");
  exp_wr_a: assert property (@(posedge clk_sys) // [RULE18]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_RATE_EXP |=>
    symbolRateExponentField == $past(regWdata[3:0]))
    else $error("exponent write lost");
  // Mode strobes lag the control byte by one more edge
  fixed_mode_a: assert property (@(posedge clk_sys) // [RULE12]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL &&
    regWdata[1:0] == 2'h0 ##1 !(regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL)
    |=> lenFixed) else $error("fixed length mode not seen");
  var_mode_a: assert property (@(posedge clk_sys) // [RULE13]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL &&
    regWdata[1:0] == 2'h1 ##1 !(regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL)
    |=> lenVariable) else $error("variable length mode not seen");
  random_src_a: assert property (@(posedge clk_sys) // [RULE8]
    disable iff (sys_rst) regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL &&
    regWdata[5:4] == 2'h2 ##1 !(regWrite && regAddr == `TXCFG_ADDR_PKT_CTRL)
    |=> srcRandom && !srcBuffer) else $error("random source not seen");
  conflict_flag_a: assert property (@(posedge clk_sys) // [RULE5]
    disable iff (sys_rst) whiteningEnable && legacyCrcCompat |=>
    whiteningConflict) else $error("whitening conflict not flagged");
  // Read answers come one edge after the strobe
  base_frequency_word_top_a: assert property (@(posedge clk_sys) // [RULE16]
    disable iff (sys_rst) regRead && regAddr == `TXCFG_ADDR_BASE_FREQUENCY_WORD_HI |=>
    regRdata[7:6] == 2'h1 && baseFrequencyWord[23:22] == 2'h1)
    else $error("base_frequency_word top bits");
  exp_upper_a: assert property (@(posedge clk_sys) // [RULE20]
    disable iff (sys_rst) regRead && regAddr == `TXCFG_ADDR_RATE_EXP |=>
    regRdata[7:4] == 4'h0 && regRdata[3:0] == $past(symbolRateExponentField))
    else $error("exponent byte read wrong");
  mant_hidden_a: assert property (@(posedge clk_sys) // [RULE19]
    disable iff (sys_rst) symbolRateMantissaFull[8] && ($stable(rateMant_q)
    || $past(regWrite && regAddr == `TXCFG_ADDR_RATE_MANT)))
    else $error("mantissa changed without write");
  // Scenarios
  cov_write_read_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    regWrite && regAddr == `TXCFG_ADDR_SYNC_HI ##2 regRead ##1 regRvalid);
  cov_conflict_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    whiteningConflict);
  cov_pin_src_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    srcAsyncPin && lenInfinite);
  cov_reserved_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    lenReserved && srcRandom);
  cov_unmapped_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    regRvalid && !regHit);
endmodule

// *** verif/txcfg_host.sv ***
// Host-side model driving the register port of the config bank
`timescale 1ns/10ps
module txcfg_host (
  // Clock
  input  wire logic       clk_sys,
  // Register port towards the bank
  output logic      [5:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid,
  input  wire logic       regHit
);
  // Idle bus at time zero
  initial begin
    regAddr  = 6'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 8'h00;
  end

  // One-cycle write strobe, moved only on falling edges
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regWdata = ~d; // Stale data never looks valid
  endtask

  // Read strobe; answer sampled while regRvalid stands
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic v, output logic h);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    d = regRdata;
    v = regRvalid;
    h = regHit;
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the transmit configuration bank
`timescale 1ns/10ps
module tb;
  import txcfg_pkg::*;
  logic        clk_sys, sys_rst, regWrite, regRead, regRvalid, regHit;
  logic [5:0]  regAddr;
  logic [7:0]  regWdata, regRdata, fixedPacketLength, channelIndex;
  logic [15:0] syncWord;
  logic [23:0] baseFrequencyWord;
  logic [3:0]  symbolRateExponentField;
  logic [8:0]  symbolRateMantissaFull;
  logic        whiteningEnable, legacyCrcCompat, crcEnable;
  logic        srcBuffer, srcSyncSerial, srcRandom, srcAsyncPin;
  logic        lenFixed, lenVariable, lenInfinite, lenReserved;
  logic        whiteningConflict;
  int          n_mismatch, comparisons, cyc, mdl[64], msk[64];
  logic [31:0] seed;

  txcfg_bank i_dut (.clk_sys, .sys_rst, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata, .regRvalid, .regHit, .syncWord,
    .fixedPacketLength, .whiteningEnable, .legacyCrcCompat, .crcEnable,
    .srcBuffer, .srcSyncSerial, .srcRandom, .srcAsyncPin, .lenFixed,
    .lenVariable, .lenInfinite, .lenReserved, .whiteningConflict,
    .channelIndex, .baseFrequencyWord, .symbolRateExponentField,
    .symbolRateMantissaFull);
  txcfg_host i_host (.clk_sys, .regAddr, .regWrite, .regRead, .regWdata,
    .regRdata, .regRvalid, .regHit);

  // Clock, plus a cycle ceiling so a hang still ends the run
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Reference image: reset value and writable mask per address
  task automatic mreset();
    foreach (mdl[i]) begin
      mdl[i] = 0;
      msk[i] = 0;
    end
    mdl[4] = 'hD3; mdl[5] = 'h91; mdl[6] = 'hFF; mdl[8] = 'h45;
    mdl[13] = 'h5E; mdl[14] = 'hC4; mdl[15] = 'hEC;
    mdl[16] = 'h0C; mdl[17] = 'h22;
    foreach (msk[i]) if (i inside {4, 5, 6, 10, 14, 15, 17}) msk[i] = 'hFF;
    msk[8] = 'h7F;
    msk[13] = 'h3F;
    msk[16] = 'h0F;
  endtask

  // put never sets whitening together with legacy CRC; it clears bit 6 when bit 3 is set
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    if (a == 6'h08 && d[3]) d[6] = 1'b0;
    i_host.wr(a, d);
    mdl[a] = (d & msk[a]) | (mdl[a] & ~msk[a]);
  endtask

  task automatic get(input logic [5:0] a);
    logic [7:0] d;
    logic       v, h;
    i_host.rd(a, d, v, h);
    cmp(24'(d), 24'(mdl[a]));
    cmp({22'h0, v, h}, {22'h0, 1'b1, 1'(msk[a] != 0)});
  endtask

  // Settings outputs against the reference image
  task automatic chk_out();
    int c, f, l;
    c = mdl[8];
    f = (c >> 4) & 3;
    l = c & 3;
    cmp(24'(syncWord), 24'(mdl[4] * 256 + mdl[5]));
    cmp(24'(fixedPacketLength), 24'(mdl[6]));
    cmp({21'h0, whiteningEnable, legacyCrcCompat, crcEnable},
        24'({c[6], c[3], c[2]}));
    cmp({20'h0, srcAsyncPin, srcRandom, srcSyncSerial, srcBuffer},
        24'(1 << f));
    cmp({20'h0, lenReserved, lenInfinite, lenVariable, lenFixed},
        24'(1 << l));
    cmp(24'(whiteningConflict), 24'(c[6] & c[3]));
    cmp(24'(channelIndex), 24'(mdl[10]));
    cmp(baseFrequencyWord,
        24'(mdl[13] * 65536 + mdl[14] * 256 + mdl[15]));
    cmp(24'(symbolRateExponentField), 24'(mdl[16]));
    cmp(24'(symbolRateMantissaFull), 24'(256 + mdl[17]));
  endtask

  task automatic do_reset(input int n);
    sys_rst = 1'b1;
    repeat (n) @(negedge clk_sys);
    sys_rst = 1'b0;
    mreset();
    repeat (2) @(negedge clk_sys);
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    seed = 32'hA4D194F2;
    do_reset(16);
    chk_out();
    for (int a = 0; a < 64; a++) get(6'(a));
    // Write then read back the same byte
    put(6'h04, 8'hA5);
    get(6'h04);
    // Every source format and length code
    for (int i = 0; i < 16; i++) begin
      put(6'h08, 8'(8'hC4 | ((i >> 2) << 4) | (i & 3)));
      @(negedge clk_sys);
      chk_out();
    end
    // Misuse on purpose: the bank keeps both bits and only flags it
    i_host.wr(6'h08, 8'h48);
    mdl[8] = 'h48;
    @(negedge clk_sys);
    chk_out();
    // Random traffic over mapped and unmapped places
    for (int n = 0; n < 300; n++) begin
      r = xs();
      put(r[5:0], r[15:8]);
      if (r[16]) get(r[5:0]);
      else @(negedge clk_sys);
      chk_out();
    end
    // Second reset in mid-run restores every default
    do_reset(2);
    chk_out();
    get(6'h08);
    close_out();
  end
endmodule
